// *** ssic_pkg.sv ***
// Purpose: Shared constants for the supply-regulator I2C link, both ends
// Assumes: 200 MHz system clock at both ends
// Notes:   Register is one byte; bit positions below
package ssic_pkg;
    localparam logic [6:0] SSIC_SLAVE_ADDR  = 7'h08;
    localparam logic [7:0] SSIC_REG_RESET   = 8'h00;
    localparam int         SSIC_BIT_PLM     = 7;
    localparam int         SSIC_BIT_CRS     = 6;
    localparam int         SSIC_BIT_TONE    = 5;
    localparam int         SSIC_BIT_LCOMP   = 4;
    localparam int         SSIC_BIT_VOLTAGE_SELECT    = 3;
    localparam int         SSIC_BIT_PWREN   = 2;
    localparam int         SSIC_BIT_OTF     = 1;
    localparam int         SSIC_BIT_OLF     = 0;
    localparam logic [7:0] SSIC_CTRL_MASK   = 8'hfc;
    // Output level codes: {line_compensation, voltage_select}
    localparam logic [1:0] SSIC_LVL_13V     = 2'h0;
    localparam logic [1:0] SSIC_LVL_18V     = 2'h1;
    localparam logic [1:0] SSIC_LVL_14V     = 2'h2;
    localparam logic [1:0] SSIC_LVL_19V     = 2'h3;
    // Host register map (Wishbone byte offsets)
    localparam logic [3:0] SSIC_OFS_CTRL    = 4'h0;
    localparam logic [3:0] SSIC_OFS_WDATA   = 4'h4;
    localparam logic [3:0] SSIC_OFS_RDATA   = 4'h8;
    localparam logic [3:0] SSIC_OFS_STAT    = 4'hc;
    localparam logic [3:0] SSIC_OFS_MASK    = 4'h0 + 4'h0;
    localparam int         SSIC_CTRL_GO     = 0;
    localparam int         SSIC_CTRL_READ   = 1;
    localparam int         SSIC_IRQ_DONE    = 0;
    localparam int         SSIC_IRQ_NACK    = 1;
    // SCL half period in system clocks (200 MHz / 4 = 50 MHz max; use 60ns-class default 12)
    localparam int         SSIC_SCL_HALF    = 12;
endpackage

// *** ssic_if.sv ***
// Purpose: Two-wire link between host master and supply device
// Assumes: Pull-ups resolve released lines to 1
// Notes:   Enables are active low (low = drive low)
`timescale 1ns/1ps
`default_nettype none
interface ssic_if;
    logic sclOeN;
    logic sdaHostOeN;
    logic sdaDevOeN;
    wire  scl = sclOeN;
    wire  sda = sdaHostOeN & sdaDevOeN;
    modport host (output sclOeN, output sdaHostOeN, input scl, input sda);
    modport dev  (output sdaDevOeN, input scl, input sda);
endinterface
`default_nettype wire

// *** ssic_dev.sv ***
// Purpose: Device end: I2C slave with one system register
// Assumes: SCL and SDA are asynchronous, sampled by clk_sys
// Notes:   Outputs reflect register fields for the analogue blocks
// Behaviour
// - Answer address 0001000, LSB 1 means read
// - Write is start, address, one byte, stop
// - One byte register, documented field order
// - Register clears to zero at power-on
// - Write stores upper six bits only
// - Power enable zero disables, closes loop-through
// - Tone enable overrides external tone key
// - Mode bit: zero pulsed, one static limiting
// - Read returns register MSB first
// - Master ack continues read, nack ends
// - Control bits read as last written
// - Overtemperature sets flag, disables power
// - Lockout ignores bus, holds register zero
// - Interface operates after supply-good rises
// - Acknowledge each byte, none in lockout
// - Bytes are eight bits MSB first plus ack
`timescale 1ns/1ps
`default_nettype none
module ssic_dev
    import ssic_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // Bus
    ssic_if.dev             bus,
    // Supply, diagnostics and tone key
    input  wire logic       supplyGood,
    input  wire logic       overTemp,
    input  wire logic       overLoad,
    input  wire logic       tone_key_input,
    // Regulator controls and register view
    output logic            powerOn,
    output logic            loopThroughClosed,
    output logic [1:0]      outLevel,
    output logic            toneOn,
    output logic            currentRangeHigh,
    output logic            staticLimit,
    output logic [7:0]      regView
);
    typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_WBYTE, ST_WACK, ST_RBYTE, ST_RACK, ST_IGNORE} ssic_dev_st_type;

    ////////////////////////////////////////////////////////////////
    logic [1:0] sclSync_q, sdaSync_q, pgSync_q, keySync_q;
    logic       sclPrev_q, sdaPrev_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sclSync_q <= 2'h3;
            sdaSync_q <= 2'h3;
            pgSync_q  <= 2'h0;
            keySync_q <= 2'h0;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclSync_q <= {sclSync_q[0], bus.scl};
            sdaSync_q <= {sdaSync_q[0], bus.sda};
            pgSync_q  <= {pgSync_q[0], supplyGood};
            keySync_q <= {keySync_q[0], tone_key_input};
            sclPrev_q <= sclSync_q[1];
            sdaPrev_q <= sdaSync_q[1];
        end
    end

    // Diagnostic levels arrive from the analogue side with no relation to clk_sys
    logic [1:0] otSync_q, olSync_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            otSync_q <= 2'h0;
            olSync_q <= 2'h0;
        end else begin
            otSync_q <= {otSync_q[0], overTemp};
            olSync_q <= {olSync_q[0], overLoad};
        end
    end

    wire sclS    = sclSync_q[1];
    wire sdaS    = sdaSync_q[1];
    wire pgood   = pgSync_q[1];
    wire otS     = otSync_q[1];
    wire olS     = olSync_q[1];
    wire sclRise = sclS & ~sclPrev_q;
    wire sclFall = ~sclS & sclPrev_q;
    wire startC  = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    wire stopC   = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

    ////////////////////////////////////////////////////////////////
    ssic_dev_st_type st_q;
    logic [7:0] shift_q, sysReg_q;
    logic [2:0] bitCnt_q;
    logic       sdaLow_q;
    logic       gotBit_q;

    wire addrHit  = (shift_q[7:1] == SSIC_SLAVE_ADDR);
    wire isRead   = shift_q[0];
    wire [7:0] liveReg = {sysReg_q[7:2], otS, olS};
    // Flag bits keep their own source; a write can only touch the six control bits
    wire [7:0] wrMerge = (shift_q & SSIC_CTRL_MASK) | (sysReg_q & ~SSIC_CTRL_MASK);

    // Lockout outranks everything and stop outranks start, so a sagging supply never leaves a half-written byte
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q     <= ST_IDLE;
            shift_q  <= 8'h00;
            sysReg_q <= SSIC_REG_RESET;
            bitCnt_q <= 3'h0;
            sdaLow_q <= 1'b0;
            gotBit_q <= 1'b0;
        end else if (!pgood) begin
            st_q     <= ST_IDLE;
            sysReg_q <= SSIC_REG_RESET;
            sdaLow_q <= 1'b0;
        end else if (stopC) begin
            st_q     <= ST_IDLE;
            sdaLow_q <= 1'b0;
        end else if (startC) begin
            st_q     <= ST_ADDR;
            bitCnt_q <= 3'h0;
            gotBit_q <= 1'b0;
            sdaLow_q <= 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE, ST_IGNORE: begin
                    sdaLow_q <= 1'b0;
                end
                ST_ADDR, ST_WBYTE: begin
                    if (sclRise) begin
                        shift_q  <= {shift_q[6:0], sdaS};
                        bitCnt_q <= bitCnt_q + 3'h1;
                        gotBit_q <= 1'b1;
                    end
                    // The fall right after a start also sees a zero count; only one after eight bits ends a byte
                    if (sclFall && bitCnt_q == 3'h0 && gotBit_q) begin
                        gotBit_q <= 1'b0;
                        if (st_q == ST_ADDR && !addrHit) begin
                            st_q <= ST_IGNORE;
                        end else begin
                            sdaLow_q <= 1'b1;
                            st_q     <= (st_q == ST_ADDR) ? ST_AACK : ST_WACK;
                            if (st_q == ST_WBYTE) begin
                                sysReg_q <= wrMerge;
                            end
                        end
                    end
                end
                ST_AACK, ST_WACK: begin
                    if (sclFall) begin
                        if (st_q == ST_AACK && isRead) begin
                            st_q     <= ST_RBYTE;
                            shift_q  <= liveReg;
                            sdaLow_q <= ~liveReg[7];
                            bitCnt_q <= 3'h1;
                        end else begin
                            st_q     <= ST_WBYTE;
                            sdaLow_q <= 1'b0;
                            bitCnt_q <= 3'h0;
                        end
                    end
                end
                ST_RBYTE: begin
                    if (sclFall) begin
                        if (bitCnt_q == 3'h0) begin
                            st_q     <= ST_RACK;
                            sdaLow_q <= 1'b0;
                        end else begin
                            sdaLow_q <= ~shift_q[3'h7 - bitCnt_q];
                            bitCnt_q <= bitCnt_q + 3'h1;
                        end
                    end
                end
                ST_RACK: begin
                    // A released line at the ninth clock is a master nack: stay quiet until the next start
                    if (sclRise) begin
                        st_q <= sdaS ? ST_IGNORE : ST_RACK;
                    end else if (sclFall) begin
                        st_q     <= ST_RBYTE;
                        shift_q  <= liveReg;
                        sdaLow_q <= ~liveReg[7];
                        bitCnt_q <= 3'h1;
                    end
                end
            endcase
        end
    end

    // Open drain: the enable goes low only to pull the line down
    assign bus.sdaDevOeN = ~sdaLow_q;

    ////////////////////////////////////////////////////////////////
    // Overtemperature cuts power at once but leaves the stored enable bit, so a read still shows what was written
    wire pwr = sysReg_q[SSIC_BIT_PWREN] & ~otS;
    assign powerOn           = pwr;
    assign loopThroughClosed = ~sysReg_q[SSIC_BIT_PWREN];
    assign outLevel          = {sysReg_q[SSIC_BIT_LCOMP], sysReg_q[SSIC_BIT_VOLTAGE_SELECT]};
    assign toneOn            = pwr & (sysReg_q[SSIC_BIT_TONE] | keySync_q[1]);
    assign currentRangeHigh  = sysReg_q[SSIC_BIT_CRS];
    assign staticLimit       = sysReg_q[SSIC_BIT_PLM];
    assign regView           = liveReg;
endmodule // ssic_dev
`default_nettype wire

// *** ssic_host.sv ***
// Purpose: Host end: Wishbone-driven I2C master for the supply device
// Assumes: Single master on the link
// Notes:   One transfer per GO: address plus one data byte
`timescale 1ns/1ps
`default_nettype none
module ssic_host
    import ssic_pkg::*;
#(
    parameter int HALF = SSIC_SCL_HALF
)(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    output logic             irq,
    // Link
    ssic_if.host             bus
);
    if (HALF < 2 || HALF > 65536) begin : g_halfCheck
        $error("HALF out of range");
    end
    typedef enum {H_IDLE, H_START, H_BIT, H_STOP} ssic_hst_type;

    ////////////////////////////////////////////////////////////////
    logic [7:0] wData_q, rData_q, sh_q;
    logic [1:0] stat_q, mask_q;
    logic       busy_q, rd_q, ack_q, sclLow_q, sdaLow_q, nack_q;
    logic [1:0] sdaSync_q;
    logic [15:0] cnt_q;
    logic [1:0]  phase_q;
    logic [3:0]  bitN_q;
    logic        byteN_q;
    ssic_hst_type st_q;

    wire acc    = cyc_i & stb_i & ~ack_q;
    // A write lands on the edge at which the master samples ack, never a cycle earlier
    wire wr     = cyc_i & stb_i & ack_q & we_i & sel_i[0];
    wire goW    = wr & (adr_i == SSIC_OFS_CTRL) & dat_i[SSIC_CTRL_GO] & ~busy_q;
    wire tick   = (cnt_q == 16'(HALF - 1));
    wire sdaIn  = sdaSync_q[1];
    wire doneEv = (st_q == H_STOP) & tick & (phase_q == 2'h2);
    wire [1:0] ev = {doneEv & nack_q, doneEv};
    assign dat_o = (adr_i == SSIC_OFS_CTRL)  ? {31'h0, busy_q} :
                   (adr_i == SSIC_OFS_WDATA) ? {24'h0, wData_q} :
                   (adr_i == SSIC_OFS_RDATA) ? {24'h0, rData_q} :
                   (adr_i == SSIC_OFS_STAT)  ? {28'h0, mask_q, stat_q} : 32'h0;
    assign ack_o = ack_q;
    assign irq   = |(stat_q & mask_q);
    assign bus.sclOeN     = ~sclLow_q;
    assign bus.sdaHostOeN = ~sdaLow_q;
    // Bit count: 0..8 address+ack, then 0..8 again for data+ack with byteN_q set
    wire [7:0] addrByte = {SSIC_SLAVE_ADDR, rd_q};

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0; stat_q <= 2'h0; mask_q <= 2'h0;
            wData_q <= 8'h00; rData_q <= 8'h00; sdaSync_q <= 2'h3;
            busy_q <= 1'b0; rd_q <= 1'b0; nack_q <= 1'b0;
            sclLow_q <= 1'b0; sdaLow_q <= 1'b0; cnt_q <= 16'h0;
            phase_q <= 2'h0; bitN_q <= 4'h0; byteN_q <= 1'b0;
            sh_q <= 8'h00; st_q <= H_IDLE;
        end else begin
            sdaSync_q <= {sdaSync_q[0], bus.sda};
            ack_q <= acc;
            // Status bits: a set in the same cycle as a clear wins
            stat_q <= (stat_q & ~((wr && adr_i == SSIC_OFS_STAT) ? dat_i[1:0] : 2'h0)) | ev;
            if (wr && adr_i == SSIC_OFS_STAT) mask_q <= dat_i[3:2];
            if (wr && adr_i == SSIC_OFS_WDATA) wData_q <= dat_i[7:0];
            cnt_q <= (tick || st_q == H_IDLE) ? 16'h0 : cnt_q + 16'h1;
            unique case (st_q)
                H_IDLE: if (goW) begin
                    busy_q <= 1'b1; rd_q <= dat_i[SSIC_CTRL_READ]; nack_q <= 1'b0;
                    st_q <= H_START; sdaLow_q <= 1'b1; phase_q <= 2'h0;
                end
                H_START: if (tick) begin
                    sclLow_q <= 1'b1; st_q <= H_BIT; bitN_q <= 4'h0; byteN_q <= 1'b0;
                    sh_q <= addrByte; sdaLow_q <= ~addrByte[7];
                end
                H_BIT: if (tick) begin
                    if (sclLow_q) sclLow_q <= 1'b0;
                    else begin
                        sclLow_q <= 1'b1;
                        if (bitN_q == 4'h8) begin
                            if (sdaIn && !(byteN_q && rd_q)) nack_q <= 1'b1;
                            if (byteN_q) begin
                                st_q <= H_STOP; phase_q <= 2'h0; sdaLow_q <= 1'b1;
                            end else begin
                                byteN_q <= 1'b1; bitN_q <= 4'h0;
                                sh_q <= rd_q ? 8'hff : wData_q;
                                sdaLow_q <= rd_q ? 1'b0 : ~wData_q[7];
                            end
                        end else begin
                            if (byteN_q && rd_q) sh_q <= {sh_q[6:0], sdaIn};
                            bitN_q <= bitN_q + 4'h1;
                            // Single byte read ends with nack (high) at ninth clock
                            sdaLow_q <= (bitN_q == 4'h7) ? ~(!byteN_q && !rd_q ? 1'b1 : (!byteN_q)) & (!byteN_q)
                                                         : ~sh_q[3'h6 - bitN_q[2:0]] & ~(byteN_q & rd_q);
                        end
                    end
                end
                H_STOP: if (tick) begin
                    if (phase_q == 2'h0) sclLow_q <= 1'b0;
                    else if (phase_q == 2'h1) sdaLow_q <= 1'b0;
                    else begin
                        st_q <= H_IDLE; busy_q <= 1'b0;
                        if (rd_q) rData_q <= sh_q;
                    end
                    phase_q <= phase_q + 2'h1;
                end
            endcase
        end
    end
endmodule // ssic_host
`default_nettype wire

// *** ssic_checker.sv ***
// Purpose: Wire-level checks of the two-wire link between host and device ends
// Assumes: Signals taken straight off the interface, released lines read high
// Notes:   Bit counter restarts at every start; stray stop clocks land past byte 0
`timescale 1ns/1ps
`default_nettype none
module ssic_checker
    import ssic_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // Link
    input  wire logic sclOeN,
    input  wire logic sdaHostOeN,
    input  wire logic sdaDevOeN,
    input  wire logic scl,
    input  wire logic sda
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic       scl_q, sda_q, rw_q;
    logic [3:0] bitCnt_q;
    logic [1:0] byteIdx_q;
    logic [7:0] addr_q;
    wire startSeen = scl_q && scl && sda_q && !sda;
    wire sclRise   = scl && !scl_q;
    wire hiSteady  = scl && scl_q;
    wire rdMode    = rw_q && (byteIdx_q != 2'h0);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            {scl_q, sda_q, rw_q, bitCnt_q, byteIdx_q, addr_q} <= {2'h3, 1'h0, 4'h0, 2'h0, 8'h00};
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (startSeen) begin
                {bitCnt_q, byteIdx_q} <= 6'h00;
            end else if (sclRise) begin
                bitCnt_q <= (bitCnt_q == 4'h9) ? 4'h1 : bitCnt_q + 4'h1;
                if (bitCnt_q == 4'h9 && byteIdx_q != 2'h3) byteIdx_q <= byteIdx_q + 2'h1;
                if (byteIdx_q == 2'h0 && bitCnt_q < 4'h8) addr_q <= {addr_q[6:0], sda};
                if (byteIdx_q == 2'h0 && bitCnt_q == 4'h7) rw_q <= sda;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_devChangeSclLow; $changed(sdaDevOeN) |-> !scl && !scl_q; endproperty
    a_devChangeSclLow: assert property (p_devChangeSclLow) else $error("device moved data while clock high");
    property p_devAckSlot; hiSteady && !sdaDevOeN && !rdMode |-> bitCnt_q == 4'h9; endproperty
    a_devAckSlot: assert property (p_devAckSlot) else $error("device pulled data outside ack slot");
    property p_addrMatch; hiSteady && !sdaDevOeN && byteIdx_q == 2'h0 |-> addr_q[7:1] == SSIC_SLAVE_ADDR; endproperty
    a_addrMatch: assert property (p_addrMatch) else $error("device acked a foreign address");
    property p_hostAckRelease; hiSteady && bitCnt_q == 4'h9 && !rdMode |-> sdaHostOeN; endproperty
    a_hostAckRelease: assert property (p_hostAckRelease) else $error("host drove data in ack slot");
    property p_devQuietAddr; hiSteady && byteIdx_q == 2'h0 && bitCnt_q != 4'h9 |-> sdaDevOeN; endproperty
    a_devQuietAddr: assert property (p_devQuietAddr) else $error("device drove during address byte");
    property p_sclLowBounded; $fell(scl) |-> ##[1:100] scl; endproperty
    a_sclLowBounded: assert property (p_sclLowBounded) else $error("clock stuck low");
    property p_startClocked; startSeen |-> ##[1:200] !scl; endproperty
    a_startClocked: assert property (p_startClocked) else $error("start not followed by clocks");
    property p_resetReleased; $rose(resetn) |-> sclOeN && sdaHostOeN && sdaDevOeN; endproperty
    a_resetReleased: assert property (p_resetReleased) else $error("link driven after reset");
    c_start: cover property (startSeen);
    c_addrAck: cover property (hiSteady && bitCnt_q == 4'h9 && byteIdx_q == 2'h0 && !sdaDevOeN);
    c_readBit: cover property (hiSteady && rdMode && !sdaDevOeN);
endmodule // ssic_checker
`default_nettype wire

// *** satellite_supply_i2c_ctrl_tb_top.sv ***
// Purpose: Drives the host end over Wishbone and checks the device end across the link
// Assumes: 200 MHz clock, both ends at default link speed
// Notes:   Reads are noted in a queue and compared by a separate monitor
`timescale 1ns/1ps
`default_nettype none
module satellite_supply_i2c_ctrl_tb_top
    import ssic_pkg::*;
;
    logic        clk_sys, resetn, cyc, stb, we, chkReq, supplyGood, overTemp, overLoad, toneKey, ackO, irq;
    logic        pwrOut, ltc, toneOut, crh, stl;
    logic [1:0]  outLevel;
    logic [3:0]  adr;
    logic [7:0]  regView, ctrl, d;
    logic [15:0] note;
    logic [31:0] wdat, rdat, datO;
    logic [15:0] notes[$];
    int          num_errors = 0, n_checks = 0, cycles = 0;
    ssic_if link();
    ssic_host #(.HALF(SSIC_SCL_HALF)) ssic_host_inst (.clk_sys(clk_sys), .resetn(resetn), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(datO), .ack_o(ackO), .irq(irq), .bus(link));
    ssic_dev ssic_dev_inst (.clk_sys(clk_sys), .resetn(resetn), .bus(link), .supplyGood(supplyGood),
        .overTemp(overTemp), .overLoad(overLoad), .tone_key_input(toneKey), .powerOn(pwrOut), .loopThroughClosed(ltc),
        .outLevel(outLevel), .toneOn(toneOut), .currentRangeHigh(crh), .staticLimit(stl), .regView(regView));
    ssic_checker ssic_checker_inst (.clk_sys(clk_sys), .resetn(resetn), .sclOeN(link.sclOeN),
        .sdaHostOeN(link.sdaHostOeN), .sdaDevOeN(link.sdaDevOeN), .scl(link.scl), .sda(link.sda));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s, input logic [7:0] m);
        n_checks++;
        if ((s & m) !== (e & m)) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e & m, s & m);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled, then drop for a cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] dv, input logic c);
        @(posedge clk_sys);
        {cyc, stb, we, adr, wdat, chkReq} <= {2'h3, w, a, dv, c};
        @(posedge clk_sys);
        while (ackO !== 1'b1) @(posedge clk_sys);
        rdat = datO;
        {cyc, stb} <= 2'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        notes.push_back({m, e});
        wb(1'b0, a, 32'h0, 1'b1);
    endtask
    task automatic xfer(input logic rdOp, input logic [7:0] dv, input logic nack, input logic msk);
        wb(1'b1, SSIC_OFS_STAT, {28'h0, {2{msk}}, 2'h0}, 1'b0);
        wb(1'b1, SSIC_OFS_WDATA, {24'h0, dv}, 1'b0);
        wb(1'b1, SSIC_OFS_CTRL, {30'h0, rdOp, 1'b1}, 1'b0);
        rdat = 32'h1;
        while (rdat[0] !== 1'b0) wb(1'b0, SSIC_OFS_CTRL, 32'h0, 1'b0);
        repeat (2) @(negedge clk_sys);
        check("irq raised", {7'h0, msk}, {7'h0, irq}, 8'h01);
        rd(SSIC_OFS_STAT, {4'h0, msk, msk, nack, 1'b1}, 8'h0f);
        wb(1'b1, SSIC_OFS_STAT, 32'h3, 1'b0);
        repeat (2) @(negedge clk_sys);
        check("irq cleared", 8'h00, {7'h0, irq}, 8'h01);
    endtask
    task automatic checkOutputs();
        logic [7:0] e;
        logic [7:0] m;
        @(negedge clk_sys);
        e = {ctrl[7:6], ctrl[5] | toneKey, ctrl[4:3], ctrl[2] & ~overTemp, ~ctrl[2], 1'b0};
        m = {2'h3, {3{ctrl[2] & ~overTemp}}, 1'b1, ~overTemp, 1'b0};
        check("regulator outputs", e, {stl, crh, toneOut, outLevel, pwrOut, ltc, 1'b0}, m);
        check("register view", {ctrl[7:2], overTemp, overLoad}, regView, 8'hff);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        if (cyc && stb && ackO === 1'b1 && chkReq && !we) begin
            note = notes.pop_front();
            check("read data", note[7:0], datO[7:0], note[15:8]);
        end
    end
    // Roughly 21 transfers of about 500 cycles each fit well below this
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        {resetn, cyc, stb, we, chkReq, supplyGood, overTemp, overLoad, toneKey} = 9'h0;
        {adr, wdat, ctrl, d} = 52'h0;
        void'($urandom(39683));
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        checkOutputs();
        // Supply still low: byte must be refused and nothing stored
        xfer(1'b0, 8'hfc, 1'b1, 1'b0);
        checkOutputs();
        @(posedge clk_sys);
        supplyGood <= 1'b1;
        repeat (8) @(posedge clk_sys);
        wb(1'b0, 4'h2, 32'h0, 1'b0);
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            {overTemp, overLoad, toneKey} <= 3'($urandom);
            ctrl = d & SSIC_CTRL_MASK;
            xfer(1'b0, d, 1'b0, i == 2);
            checkOutputs();
            xfer(1'b1, 8'h00, 1'b0, 1'b0);
            rd(SSIC_OFS_RDATA, {ctrl[7:2], overTemp, overLoad}, 8'hff);
        end
        resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        // Let the flag synchronisers refill before looking at the live bits
        repeat (3) @(posedge clk_sys);
        ctrl = 8'h00;
        checkOutputs();
        print_verdict();
    end
endmodule // satellite_supply_i2c_ctrl_tb_top
`default_nettype wire
